// ===== postst_top.sv
`timescale 1ns/100ps
// Operation
// RQ1 - self-test starts at power-up reset and again on each host bus initialization.
// RQ2 - the whole sequence ends within ten seconds, with or without nodes on the storage bus; the code flags an overrun only, hold time excluded.
// RQ3 - at start green and all five reds light, and one red goes out per passing step.
// RQ4 - each failure is fatal or nonfatal; fatal stops service, nonfatal lets operation go on.
// RQ5 - any failure places an error code in the host-visible status address register.
// RQ6 - after a fatal failure the processors idle until the host initializes the device.
// RQ7 - a nonfatal failure keeps green lit and shows its red code for at least ten seconds.
// RQ8 - a fatal failure turns green off and holds a red pattern naming the failing test.
// RQ9 - four nonfatal conditions each have a distinct code.
// RQ10 - each failing test has its own distinct fatal code.
// RQ11 - buffer memory data failures have one fatal code per 4-bit slice and per 64K half.
// RQ12 - on a configuration table error the operator sets switch 1 on, reboots and reprograms.
// RQ13 - a configuration table error shows green off with reds 0 and 1 lit, code 03.
// RQ14 - the reds come from a registered 5-bit code, bit 0 is red 0, stable between steps.
module postst_top
  import postst_pkg::*;
#(
  parameter int unsigned HOLD_CYC  = NONFATAL_CYC,
  parameter int unsigned LIMIT_CYC = POWER_ON_SELF_TEST_LIMIT_CYC
)(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        host_init_pin,
  input  wire logic        test_done,
  input  wire logic        test_fail,
  input  wire logic        test_fatal,
  input  wire logic [4:0]  test_code,
  output logic             test_start,
  output logic [2:0]       test_index,
  output logic             green_led,
  output logic [4:0]       red_led,
  output logic [5:0]       status_address_reg,
  output logic             service_enable,
  output logic             processor_halt,
  output logic             power_on_self_test_busy,
  output logic             power_on_self_test_timeout
);
  typedef enum {S_START, S_RUN, S_WAIT, S_HOLD, S_PASS, S_HALT} postst_state_type;

  postst_state_type state_q;
  logic [2:0]       init_sync_q;
  logic             init_level_q;
  logic             init_event;
  logic [2:0]       step_q;
  logic [31:0]      hold_q;
  logic [31:0]      limit_q;
  logic             start_q;
  logic             green_q;
  logic [4:0]       red_q;
  logic [5:0]       status_q;
  logic             running_q;
  logic             svc_q;
  logic             halt_q;
  logic             tout_q;
  postst_step_if    step ();

  // host init comes from the backplane: three stages, change once stages 2 and 3 agree
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      init_sync_q  <= 3'h0;
      init_level_q <= 1'b0;
    end else begin
      init_sync_q <= {init_sync_q[1:0], host_init_pin};
      if (init_sync_q[1] == init_sync_q[2]) begin
        init_level_q <= init_sync_q[2];
      end
    end
  end
  assign init_event = init_level_q == 1'b0 && init_sync_q[1] && init_sync_q[2];

  postst_step_eval postst_step_eval_i (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .test_done  (test_done),
    .test_fail  (test_fail),
    .test_fatal (test_fatal),
    .test_code  (test_code),
    .step       (step)
  );
  assign step.start = start_q;
  assign step.index = step_q;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q  <= S_START;
      step_q   <= 3'h0;
      start_q  <= 1'b0;
      hold_q   <= 32'h0;
      green_q  <= 1'b1;
      red_q    <= RED_ALL_ON;
      status_q <= STATUS_CLEAR;
      svc_q    <= 1'b0;
      halt_q   <= 1'b0;
    end else if (init_event) begin
      // host init restarts the sequence from any state, also out of the fatal loop; see RQ1 RQ6
      state_q  <= S_START;
      step_q   <= 3'h0;
      start_q  <= 1'b0;
      green_q  <= 1'b1;
      red_q    <= RED_ALL_ON;
      status_q <= STATUS_CLEAR;
      svc_q    <= 1'b0;
      halt_q   <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        S_START: begin
          green_q <= 1'b1; // see RQ3
          red_q   <= RED_ALL_ON; // see RQ3
          state_q <= S_RUN;
        end
        S_RUN: begin
          start_q <= 1'b1;
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (step.done) begin
            if (step.sev == POSTST_FATAL) begin
              // fatal: green off, failing test's code frozen on reds; see RQ8 RQ10 RQ11 RQ13
              green_q <= 1'b0;
              red_q   <= step.code; // see RQ14
              status_q <= {1'b1, step.code}; // see RQ5
              halt_q  <= 1'b1; // see RQ6
              state_q <= S_HALT;
            end else if (step.sev == POSTST_NONFATAL) begin
              red_q   <= step.code; // see RQ7 RQ9
              status_q <= {1'b0, step.code}; // see RQ5
              hold_q  <= 32'h0;
              state_q <= S_HOLD;
            end else begin
              red_q   <= red_q >> 1; // one red goes out per passed step, see RQ3
              if (step_q == 3'(NUM_STEPS - 1)) begin
                state_q <= S_PASS;
              end else begin
                step_q  <= step_q + 3'h1;
                state_q <= S_RUN;
              end
            end
          end
        end
        S_HOLD: begin
          // a long hold costs self-test time, but the code must stay visible; see RQ7
          if (hold_q >= HOLD_CYC - 1) begin
            red_q <= RED_ALL_ON >> (step_q + 3'h1);
            if (step_q == 3'(NUM_STEPS - 1)) begin
              state_q <= S_PASS;
            end else begin
              step_q  <= step_q + 3'h1;
              state_q <= S_RUN;
            end
          end else begin
            hold_q <= hold_q + 32'h1;
          end
        end
        S_PASS: begin
          red_q   <= RED_ALL_OFF;
          svc_q   <= 1'b1; // nonfatal failures still allow service, see RQ4
        end
        S_HALT: begin
          svc_q   <= 1'b0; // closed idle loop, only host init leaves, see RQ6
        end
        default: state_q <= S_START;
      endcase
    end
  end

  // watchdog on self-test time outside nonfatal holds; flags an overrun without aborting
  always_ff @(posedge sys_clk) begin
    if (!rstn || init_event) begin
      limit_q <= 32'h0;
      tout_q  <= 1'b0;
    end else if (state_q != S_PASS && state_q != S_HALT && state_q != S_HOLD) begin
      if (limit_q >= LIMIT_CYC) begin
        tout_q <= 1'b1; // see RQ2
      end else begin
        limit_q <= limit_q + 32'h1;
      end
    end
  end

  // registered so that busy drops at the same edge at which service_enable rises
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      running_q <= 1'b1;
    end else begin
      running_q <= state_q != S_PASS && state_q != S_HALT;
    end
  end

  assign test_start         = start_q;
  assign test_index         = step_q;
  assign green_led          = green_q;
  assign red_led            = red_q;
  assign status_address_reg = status_q;
  assign service_enable     = svc_q;
  assign processor_halt     = halt_q;
  assign power_on_self_test_busy          = running_q;
  assign power_on_self_test_timeout       = tout_q;

  a_fatal_green_off: assert property (@(posedge sys_clk) disable iff (!rstn) // see RQ8
    (state_q == S_WAIT && step.done && step.sev == POSTST_FATAL && !init_event)
    |=> !green_led && processor_halt) else $error("fatal did not halt");
  a_fatal_sa_code: assert property (@(posedge sys_clk) disable iff (!rstn) // see RQ5
    (state_q == S_WAIT && step.done && step.sev == POSTST_FATAL && !init_event)
    |=> status_address_reg == {1'b1, $past(step.code)}) else $error("bad fatal code");
  a_halt_stays: assert property (@(posedge sys_clk) disable iff (!rstn) // see RQ6
    (state_q == S_HALT && !init_event) |=> state_q == S_HALT && $stable(red_led))
    else $error("halt left without init");
  a_init_restart: assert property (@(posedge sys_clk) disable iff (!rstn) // see RQ1
    init_event |=> green_led && red_led == RED_ALL_ON) else $error("init no restart");
  a_nonfatal_green: assert property (@(posedge sys_clk) disable iff (!rstn) // see RQ7
    state_q == S_HOLD |-> green_led && !processor_halt) else $error("green lost");
  a_hold_stable: assert property (@(posedge sys_clk) disable iff (!rstn) // see RQ14
    (state_q == S_HOLD && $past(state_q) == S_HOLD && !$past(init_event)) |-> $stable(red_led))
    else $error("code changed in hold");
  a_pass_leds: assert property (@(posedge sys_clk) disable iff (!rstn) // see RQ3
    (state_q == S_PASS && $past(state_q) == S_PASS) |-> green_led && red_led == RED_ALL_OFF)
    else $error("pass leds wrong");
  a_hold_length: assert property (@(posedge sys_clk) disable iff (!rstn) // see RQ7
    ($rose(state_q == S_HOLD)) |-> hold_q == 32'h0) else $error("hold count not cleared");
  c_pass: cover property (@(posedge sys_clk) state_q == S_PASS);
  c_fatal: cover property (@(posedge sys_clk) state_q == S_HALT);
  c_nonfatal: cover property (@(posedge sys_clk) state_q == S_HOLD);
  c_recover: cover property (@(posedge sys_clk) state_q == S_HALT ##1 init_event);
endmodule // postst_top

// ===== postst_pkg.sv
package postst_pkg;
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned NONFATAL_SEC   = 10;
  localparam int unsigned NONFATAL_CYC   = NONFATAL_SEC * CLK_HZ;
  localparam int unsigned POWER_ON_SELF_TEST_LIMIT_SEC = 10;
  localparam int unsigned POWER_ON_SELF_TEST_LIMIT_CYC = POWER_ON_SELF_TEST_LIMIT_SEC * CLK_HZ - 1;
  localparam int unsigned RED_WIDTH      = 5;
  localparam int unsigned NUM_STEPS      = 5;
  localparam int unsigned CODE_WIDTH     = 6;
  localparam logic [4:0] RED_ALL_ON      = 5'h1f;
  localparam logic [4:0] RED_ALL_OFF     = 5'h00;
  // nonfatal indicator codes
  localparam logic [4:0] NF_CSR_PARITY   = 5'h01;
  localparam logic [4:0] NF_PORT_ERR     = 5'h02;
  localparam logic [4:0] NF_RAM_RETRY    = 5'h04;
  localparam logic [4:0] NF_WATCHDOG     = 5'h08;
  // fatal indicator codes
  localparam logic [4:0] F_CTRL_DECODE   = 5'h01;
  localparam logic [4:0] F_HOST_IF       = 5'h02;
  localparam logic [4:0] F_CONFIG_TABLE  = 5'h03;
  localparam logic [4:0] F_AUX_ROM       = 5'h04;
  localparam logic [4:0] F_AUX_DPM_LO    = 5'h05;
  localparam logic [4:0] F_AUX_DPM_HI    = 5'h06;
  localparam logic [4:0] F_CPU           = 5'h07;
  localparam logic [4:0] F_BUS_TIMEOUT   = 5'h08;
  localparam logic [4:0] F_ROM           = 5'h09;
  localparam logic [4:0] F_LRAM_LO       = 5'h0a;
  localparam logic [4:0] F_LRAM_HI       = 5'h0b;
  localparam logic [4:0] F_VECTOR        = 5'h0c;
  localparam logic [4:0] F_STOR_TIMER    = 5'h0d;
  localparam logic [4:0] F_FIFO          = 5'h0e;
  localparam logic [4:0] F_BUF_PARITY    = 5'h0f;
  localparam logic [4:0] F_BUF_LO_BASE   = 5'h10;
  localparam logic [4:0] F_BUF_HI_BASE   = 5'h14;
  localparam logic [4:0] F_PROTOCOL      = 5'h18;
  localparam logic [4:0] F_DPM_LO        = 5'h19;
  localparam logic [4:0] F_DPM_HI        = 5'h1a;
  localparam logic [4:0] F_IRQ_PATH      = 5'h1b;
  // status register code: bit 5 marks fatal
  localparam logic [5:0] STATUS_CLEAR    = 6'h00;
  typedef enum logic [1:0] {POSTST_NONE, POSTST_NONFATAL, POSTST_FATAL} postst_sev_type;
endpackage

// ===== postst_step_if.sv
`timescale 1ns/100ps
interface postst_step_if;
  logic                  start;
  logic [2:0]            index;
  logic                  done;
  logic                  pass;
  postst_pkg::postst_sev_type sev;
  logic [4:0]            code;
  modport seq (output start, output index, input done, input pass, input sev, input code);
  modport res (input start, input index, output done, output pass, output sev, output code);
endinterface

// ===== postst_step_eval.sv
`timescale 1ns/100ps
// captures the result of the external test step once it reports
module postst_step_eval
  import postst_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire logic                 test_done,
  input  wire logic                 test_fail,
  input  wire logic                 test_fatal,
  input  wire logic [4:0]           test_code,
  postst_step_if.res                step
);
  logic                 busy_q;
  logic                 done_q;
  logic                 pass_q;
  postst_sev_type       sev_q;
  logic [4:0]           code_q;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      busy_q <= 1'b0;
    end else if (step.start) begin
      busy_q <= 1'b1;
    end else if (test_done) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      done_q <= 1'b0;
      pass_q <= 1'b0;
      sev_q  <= POSTST_NONE;
      code_q <= 5'h00;
    end else begin
      done_q <= busy_q && test_done && !step.start;
      if (busy_q && test_done) begin
        pass_q <= !test_fail;
        // classify each failure as fatal or nonfatal, see RQ4
        sev_q  <= !test_fail ? POSTST_NONE : (test_fatal ? POSTST_FATAL : POSTST_NONFATAL);
        code_q <= test_code;
      end
    end
  end

  assign step.done = done_q;
  assign step.pass = pass_q;
  assign step.sev  = sev_q;
  assign step.code = code_q;
endmodule // postst_step_eval

// ===== postst_engine_model.sv
`timescale 1ns/100ps
// stands in for the step engine; fail_step of 7 means every step passes
module postst_engine_model
  import postst_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       test_start,
  input  wire logic [2:0] test_index,
  input  wire logic [2:0] fail_step,
  input  wire logic       fail_fatal,
  input  wire logic [4:0] fail_code,
  output logic            test_done,
  output logic            test_fail,
  output logic            test_fatal,
  output logic [4:0]      test_code
);
  logic       busy_q;
  logic [3:0] cnt_q;
  logic [2:0] idx_q;
  initial begin
    {busy_q, cnt_q, idx_q} = '0;
    {test_done, test_fail, test_fatal, test_code} = '0;
  end
  always @(posedge sys_clk) begin
    if (!test_start && busy_q && cnt_q == 4'h0) begin
      busy_q     <= 1'b0;
      test_done  <= 1'b1;
      test_fail  <= (idx_q == fail_step);
      test_fatal <= fail_fatal;
      test_code  <= fail_code;
    end else begin
      test_done  <= 1'b0;
      // result lines are only valid with test_done, so toggle them in between
      test_fail  <= ~test_fail;
      test_fatal <= ~test_fatal;
      test_code  <= ~test_code;
      if (test_start) begin
        busy_q <= 1'b1;
        cnt_q  <= 4'h3;
        idx_q  <= test_index;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // postst_engine_model

// ===== power_on_self_test_status_test.sv
`timescale 1ns/100ps
module power_on_self_test_status_test
  import postst_pkg::*;
;
  logic       sys_clk = 1'b0, rstn = 1'b0, host_init_pin = 1'b0;
  logic       test_done, test_fail, test_fatal, test_start, green_led;
  logic [4:0] test_code, red_led;
  logic [2:0] test_index;
  logic [5:0] status_address_reg;
  logic       service_enable, processor_halt, power_on_self_test_busy, power_on_self_test_timeout;
  logic [2:0] fail_step  = 3'h7;
  logic       fail_fatal = 1'b0;
  logic [4:0] fail_code  = 5'h00;
  int         error_cnt = 0, samples_checked = 0;
  logic [4:0] nf_codes[4] = '{NF_CSR_PARITY, NF_PORT_ERR, NF_RAM_RETRY, NF_WATCHDOG};

  always #20 sys_clk = ~sys_clk;

  postst_top #(.HOLD_CYC(20), .LIMIT_CYC(500)) postst_top_i (
    .sys_clk(sys_clk), .rstn(rstn), .host_init_pin(host_init_pin),
    .test_done(test_done), .test_fail(test_fail), .test_fatal(test_fatal),
    .test_code(test_code), .test_start(test_start), .test_index(test_index),
    .green_led(green_led), .red_led(red_led), .status_address_reg(status_address_reg),
    .service_enable(service_enable), .processor_halt(processor_halt),
    .power_on_self_test_busy(power_on_self_test_busy), .power_on_self_test_timeout(power_on_self_test_timeout));

  postst_engine_model postst_engine_model_i (
    .sys_clk(sys_clk), .test_start(test_start), .test_index(test_index),
    .fail_step(fail_step), .fail_fatal(fail_fatal), .fail_code(fail_code),
    .test_done(test_done), .test_fail(test_fail), .test_fatal(test_fatal),
    .test_code(test_code));

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic bail(input int n);
    if (n >= 2000) begin
      error_cnt++;
      conclude();
    end
  endtask

  task automatic wait_start(input logic [2:0] k);
    int n;
    n = 0;
    // a start pulse launched at the edge just passed must still be seen
    #1;
    while (!(test_start === 1'b1 && test_index === k) && n < 2000) begin
      tick();
      n++;
    end
    bail(n);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (power_on_self_test_busy !== 1'b0 && n < 2000) begin
      tick();
      n++;
    end
    bail(n);
  endtask

  // host init driven at a clock edge, held six cycles, long enough for the synchroniser
  task automatic host_init();
    @(posedge sys_clk) host_init_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    host_init_pin <= 1'b0;
  endtask

  task automatic run_pass();
    for (int k = 0; k < 5; k++) begin
      wait_start(3'(k));
      chk(red_led, 6'(5'h1f >> k));
      chk(green_led, 1);
    end
    wait_idle();
    chk(red_led, 0);
    chk(status_address_reg, 0);
    chk(service_enable, 1);
    chk(processor_halt, 0);
    chk(power_on_self_test_timeout, 0);
  endtask

  task automatic fatal_config();
    int n;
    @(posedge sys_clk) begin
      fail_step  <= 3'h2;
      fail_fatal <= 1'b1;
      fail_code  <= F_CONFIG_TABLE;
    end
    host_init();
    wait_start(2);
    n = 0;
    while (processor_halt !== 1'b1 && n < 2000) begin
      tick();
      n++;
    end
    bail(n);
    chk(green_led, 0);
    chk(red_led, 6'h03);
    chk(status_address_reg, {1'b1, F_CONFIG_TABLE});
    chk(service_enable, 0);
    repeat (100) tick();
    chk(processor_halt, 1);
    chk(power_on_self_test_busy, 0);
    chk(red_led, 6'h03);
    @(posedge sys_clk) fail_step <= 3'h7;
    host_init();
    run_pass();
  endtask

  task automatic nonfatal(input logic [4:0] c);
    int n;
    @(posedge sys_clk) begin
      fail_step  <= 3'h1;
      fail_fatal <= 1'b0;
      fail_code  <= c;
    end
    host_init();
    wait_start(1);
    n = 0;
    while (red_led !== c && n < 2000) begin
      tick();
      n++;
    end
    bail(n);
    chk(green_led, 1);
    chk(status_address_reg, {1'b0, c});
    chk(power_on_self_test_busy, 1);
    // the sample that ended the first loop already showed the code
    n = 1;
    while (red_led === c && n < 2000) begin
      tick();
      n++;
    end
    bail(n);
    chk(n >= 20, 1);
    wait_idle();
    chk(red_led, 0);
    chk(service_enable, 1);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    chk(green_led, 1);
    chk(red_led, 6'h1f);
    chk(status_address_reg, 0);
    @(posedge sys_clk) rstn <= 1'b1;
    run_pass();
    fatal_config();
    for (int i = 0; i < 4; i++) nonfatal(nf_codes[i]);
    conclude();
  end
endmodule // power_on_self_test_status_test
